// >>> core/svml_monitor.sv
// Ten-channel supply voltage monitor: window, glitch filter, calibration gating
//
// Function
// - Ten channels, each with A and B comparators.
// - Thresholds selectable from 0.075 V to 5.734 V.
// - Lowest 75 mV code acts as zero detect.
// - Channels one-four differential, five-ten single-ended.
// - Comparator reports one above trip, else zero.
// - Channel four and nine A feed output control.
// - Rise at upper, fall at lower trip point.
// - Hysteresis scales with range, off at low range.
// - Window equals B and not A.
// - Per-channel select: raw A or window on A.
// - B output keeps reporting B in window mode.
// - Filter drops pulses shorter than 64 us.
// - Filtered transitions appear after 64 us.
// - Unfiltered transitions appear after 16 us.
// - Calibrate and clear filters after reset, signal done.
// - No link status or control before calibration done.
// - All comparator status readable by host.
// - Link sees changes 16 us off, 64 us on.
//
// All state sits in one packed struct: one comb process, one register.
// Comparator and link inputs pass two flip-flops before any logic.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns

module svml_monitor import svml_pkg::*; #(
  parameter int NCH = NUM_CHAN,          // Channel count
  parameter int NGPIO = 4,               // Link-driven output controls
  parameter int CAL_US = 100,            // Calibration time in microseconds
  parameter logic [TRIP_W-1:0] HYST_MIN_CODE = 6'h10  // First code with hysteresis
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Analog comparator results (asynchronous)
  input wire logic [NCH-1:0] first_threshold_compare_i,
  input wire logic [NCH-1:0] second_threshold_compare_i,
  // Analog front-end controls
  output logic [NCH*TRIP_W-1:0] upper_trip_code_o,   // A threshold codes
  output logic [NCH*TRIP_W-1:0] lower_trip_code_o,   // B threshold codes
  output logic [NCH-1:0] hyst_en_a_o,
  output logic [NCH-1:0] hyst_en_b_o,
  output logic [NCH-1:0] remote_ground_sense_en_o,
  output logic calibrate_o,                          // Comparators auto-calibrating
  // Expander link
  output logic [NCH-1:0] expander_link_a_o,
  output logic [NCH-1:0] expander_link_b_o,
  output logic calibration_done_o,
  input wire logic [NGPIO-1:0] expander_link_gpio_i,
  output logic [NGPIO-1:0] gpio_ctrl_o,
  // Output control block
  output logic channel4_first_compare_o,
  output logic channel9_first_compare_o
);

  // ----------------------------------------------------------------
  // Derived constants and elaboration checks
  // ----------------------------------------------------------------
  localparam int CAL_CYC = CAL_US * CLK_MHZ;
  localparam int CAL_W = $clog2(CAL_CYC + 1);
  localparam int NSIG = 2 * NCH;  // Filter lanes: A path then B path

  // Refuse sizes that the lane layout and register words cannot carry
  initial begin
    if (NCH < 1 || NCH > NUM_CHAN) begin
      $error("svml_monitor: NCH must be 1 to 10");
    end
    if (NGPIO < 1 || NGPIO > 32) begin
      $error("svml_monitor: NGPIO must be 1 to 32");
    end
    if (CAL_CYC < 1) begin
      $error("svml_monitor: CAL_US must be positive");
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Input synchronisers, two stages each
    logic [NCH-1:0] a_s1;             // Comparator A, first sync stage
    logic [NCH-1:0] a_s2;             // Comparator A, synchronised
    logic [NCH-1:0] b_s1;
    logic [NCH-1:0] b_s2;
    logic [NGPIO-1:0] g_s1;           // Link controls, first sync stage
    logic [NGPIO-1:0] g_s2;
    // Filter timebase and per-lane stability
    logic [ACC_W-1:0] acc;            // Fractional divider for 8 MHz ticks
    logic tick;
    logic [NSIG-1:0][FCNT_W-1:0] cnt; // Stability counters
    logic [NSIG-1:0] shown;           // Filtered levels
    // Calibration sequencing
    svml_cal_e cal_st;
    logic [CAL_W-1:0] cal_cnt;
    // Software configuration
    logic cfg_loaded;
    logic [NCH-1:0] filt_en;
    logic [NCH-1:0] win_sel;
    logic [NCH-1:0][TRIP_W-1:0] trip_a;
    logic [NCH-1:0][TRIP_W-1:0] trip_b;
    // Registered views toward the analog front end
    logic [NCH-1:0] hyst_a;
    logic [NCH-1:0] hyst_b;
    logic [NCH-1:0] diff;             // Differential sense enables
    // Registered views toward the link and output control
    logic [NCH-1:0] link_a;
    logic [NCH-1:0] link_b;
    logic link_valid;
    logic calibrating;
    logic [NGPIO-1:0] gpio;
    logic ocb_lo;
    logic ocb_hi;
    // Read data, zero outside the cycle after a read strobe
    logic [31:0] rdata;
  } svml_state_s;

  // Registered state and its next value
  svml_state_s state_ff;
  svml_state_s nxt_state;
  svml_req_s req;

  // Bundle the port so the decode below reads as one request
  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Everything but the output control taps is computed from the registered copy, so outputs lag one cycle
  always_comb begin
    // Scratch values, each defaulted below so no latch is inferred
    logic [NCH-1:0] a_sel;
    logic [NSIG-1:0] lane;
    logic [FCNT_W-1:0] limit;
    logic [TRIP_IDX_W-1:0] idx;
    logic trip_hit;
    a_sel = '0;
    lane = '0;
    limit = '0;
    idx = '0;
    trip_hit = 1'b0;
    nxt_state = state_ff;

    // Synchronisers: first stages feed only the second stages
    // Limitation: a comparator pulse shorter than a clock may go unseen
    nxt_state.a_s1 = first_threshold_compare_i;
    nxt_state.a_s2 = state_ff.a_s1;
    nxt_state.b_s1 = second_threshold_compare_i;
    nxt_state.b_s2 = state_ff.b_s1;
    nxt_state.g_s1 = expander_link_gpio_i;
    nxt_state.g_s2 = state_ff.g_s1;

    // Tick at 8/25 of the clock; average rate is exactly 8 MHz
    // Tick spacing is three clocks, four once in every eight ticks, so filter
    // delays wander by a cycle around their nominal value
    if (state_ff.acc + ACC_W'(TICK_MHZ) >= ACC_W'(CLK_MHZ)) begin
      nxt_state.acc = state_ff.acc + ACC_W'(TICK_MHZ) - ACC_W'(CLK_MHZ);
      nxt_state.tick = 1'b1;
    end else begin
      nxt_state.acc = state_ff.acc + ACC_W'(TICK_MHZ);
      nxt_state.tick = 1'b0;
    end

    // Window select only counts once software marks configuration loaded
    // The mux sits ahead of the filter, so the window result is filtered too
    for (int c = 0; c < NCH; c++) begin
      if (state_ff.win_sel[c] && state_ff.cfg_loaded) begin
        a_sel[c] = state_ff.b_s2[c] & ~state_ff.a_s2[c];
      end else begin
        a_sel[c] = state_ff.a_s2[c];
      end
    end
    lane = {state_ff.b_s2, a_sel};  // B lane untouched by window mode

    // Stability filters: a level must hold for the full count before it shows
    // Lanes below NCH carry the A path, the upper lanes the B path
    // One counter per lane costs flops but keeps every lane independent
    for (int s = 0; s < NSIG; s++) begin
      if (state_ff.filt_en[s % NCH]) begin
        limit = FCNT_W'(FILT_ON_TICKS);
      end else begin
        limit = FCNT_W'(FILT_OFF_TICKS);
      end
      if (state_ff.cal_st == SVML_CAL_RUN) begin
        // Filters are initialised while calibration runs
        nxt_state.cnt[s] = '0;
        nxt_state.shown[s] = 1'b0;
      end else if (lane[s] == state_ff.shown[s]) begin
        // Any return to the shown level restarts the count; short pulses vanish
        nxt_state.cnt[s] = '0;
      end else if (state_ff.tick) begin
        // Count only on ticks so the delay is set in 8 MHz units
        if (state_ff.cnt[s] >= limit - FCNT_W'(1)) begin
          nxt_state.shown[s] = lane[s];
          nxt_state.cnt[s] = '0;
        end else begin
          nxt_state.cnt[s] = state_ff.cnt[s] + FCNT_W'(1);
        end
      end
    end

    // Calibration sequencer
    // Length is a parameter; the analog side calibrates while calibrate_o is high
    unique case (state_ff.cal_st)
      SVML_CAL_RUN: begin
        nxt_state.calibrating = 1'b1;
        if (state_ff.cal_cnt >= CAL_W'(CAL_CYC - 1)) begin
          nxt_state.cal_st = SVML_CAL_DONE;
          nxt_state.calibrating = 1'b0;
        end else begin
          nxt_state.cal_cnt = state_ff.cal_cnt + CAL_W'(1);
        end
      end
      SVML_CAL_DONE: begin
        // Done is final until the next reset
        nxt_state.calibrating = 1'b0;
      end
    endcase

    // Link and output control views; zero until calibration is done
    // The far end must never act on uncalibrated comparators, so both
    // status and incoming control wait for done
    if (state_ff.cal_st == SVML_CAL_DONE) begin
      nxt_state.link_a = state_ff.shown[NCH-1:0];
      nxt_state.link_b = state_ff.shown[NSIG-1:NCH];
      nxt_state.link_valid = 1'b1;
      nxt_state.gpio = state_ff.g_s2;  // Control accepted only now
    end else begin
      nxt_state.link_a = '0;
      nxt_state.link_b = '0;
      nxt_state.link_valid = 1'b0;
    end
    // Channel four and nine A results also go to output control
    nxt_state.ocb_lo = (OCB_CH_LO < NCH) ? nxt_state.link_a[OCB_CH_LO % NCH] : 1'b0;
    nxt_state.ocb_hi = (OCB_CH_HI < NCH) ? nxt_state.link_a[OCB_CH_HI % NCH] : 1'b0;

    // Sense mode is fixed by channel number
    nxt_state.diff = DIFF_MASK[NCH-1:0];

    // Codes below HYST_MIN_CODE form the zero-detect range, no hysteresis
    // Hysteresis only above the zero-detect range; analog sets the band
    for (int c = 0; c < NCH; c++) begin
      nxt_state.hyst_a[c] = state_ff.trip_a[c] >= HYST_MIN_CODE;
      nxt_state.hyst_b[c] = state_ff.trip_b[c] >= HYST_MIN_CODE;
    end

    // Register writes; unmapped addresses are ignored
    // A trip index at or above the channel count falls through, ignored
    idx = req.addr[TRIP_IDX_LSB +: TRIP_IDX_W];
    trip_hit = (req.addr[ADDR_W-1 -: 2] == TRIP_PAGE) && (32'(idx) < NCH)
               && (req.addr[TRIP_IDX_LSB-1:0] == 2'h0);
    if (req.wr) begin
      if (req.addr == ADDR_CTRL) begin
        nxt_state.cfg_loaded = req.wdata[CTRL_LOADED_BIT];
      end else if (req.addr == ADDR_FILT) begin
        nxt_state.filt_en = req.wdata[NCH-1:0];
      end else if (req.addr == ADDR_WIN) begin
        nxt_state.win_sel = req.wdata[NCH-1:0];
      end else if (trip_hit) begin
        // Thresholds per comparator; code zero is the 75 mV detect
        nxt_state.trip_a[idx] = req.wdata[TRIP_A_LSB +: TRIP_W];
        nxt_state.trip_b[idx] = req.wdata[TRIP_B_LSB +: TRIP_W];
      end
    end

    // Register reads: data stands only in the cycle after the strobe
    // Unmapped reads return zero, as do bits above a field
    nxt_state.rdata = '0;
    if (req.rd) begin
      if (req.addr == ADDR_CTRL) begin
        nxt_state.rdata[CTRL_LOADED_BIT] = state_ff.cfg_loaded;
      end else if (req.addr == ADDR_FILT) begin
        nxt_state.rdata[NCH-1:0] = state_ff.filt_en;
      end else if (req.addr == ADDR_WIN) begin
        nxt_state.rdata[NCH-1:0] = state_ff.win_sel;
      end else if (req.addr == ADDR_OUTA) begin
        nxt_state.rdata[NCH-1:0] = state_ff.link_a;
      end else if (req.addr == ADDR_OUTB) begin
        nxt_state.rdata[NCH-1:0] = state_ff.link_b;
      end else if (req.addr == ADDR_STAT) begin
        nxt_state.rdata[STAT_CALDONE_BIT] = state_ff.link_valid;
        // Raw views show the comparators ahead of the filter
      end else if (req.addr == ADDR_RAWA) begin
        nxt_state.rdata[NCH-1:0] = state_ff.a_s2;
      end else if (req.addr == ADDR_RAWB) begin
        nxt_state.rdata[NCH-1:0] = state_ff.b_s2;
      end else if (trip_hit) begin
        nxt_state.rdata[TRIP_A_LSB +: TRIP_W] = state_ff.trip_a[idx];
        nxt_state.rdata[TRIP_B_LSB +: TRIP_W] = state_ff.trip_b[idx];
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset restarts calibration, the only defined entry point
  // Asynchronous so the outputs are quiet before the clock runs
  // Trip codes restart at zero detect, calibrating sets to one; all else clears to zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= '0;
      state_ff.cal_st <= SVML_CAL_RUN;
      state_ff.calibrating <= 1'b1;
      for (int c = 0; c < NCH; c++) begin
        state_ff.trip_a[c] <= TRIP_ZERO_DETECT;
        state_ff.trip_b[c] <= TRIP_ZERO_DETECT;
      end
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // Each output is a field of the state register; no logic follows it
  // ----------------------------------------------------------------
  assign reg_rdata_o = state_ff.rdata;
  assign upper_trip_code_o = state_ff.trip_a;
  assign lower_trip_code_o = state_ff.trip_b;
  assign hyst_en_a_o = state_ff.hyst_a;
  assign hyst_en_b_o = state_ff.hyst_b;
  assign remote_ground_sense_en_o = state_ff.diff;
  assign calibrate_o = state_ff.calibrating;
  assign expander_link_a_o = state_ff.link_a;
  assign expander_link_b_o = state_ff.link_b;
  assign calibration_done_o = state_ff.link_valid;
  assign gpio_ctrl_o = state_ff.gpio;
  assign channel4_first_compare_o = state_ff.ocb_lo;
  assign channel9_first_compare_o = state_ff.ocb_hi;

endmodule

// >>> core/svml_pkg.sv
// Shared constants for the supply voltage monitor logic
package svml_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;  // Bit 0: configuration loaded
  localparam logic [ADDR_W-1:0] ADDR_FILT = 8'h04;  // Per-channel glitch filter enable
  localparam logic [ADDR_W-1:0] ADDR_WIN = 8'h08;   // Per-channel window select for A output
  localparam logic [ADDR_W-1:0] ADDR_OUTA = 8'h0c;  // Reported A outputs (read only)
  localparam logic [ADDR_W-1:0] ADDR_OUTB = 8'h10;  // Reported B outputs (read only)
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h14;  // Status (read only)
  localparam logic [ADDR_W-1:0] ADDR_RAWA = 8'h18;  // Synchronised raw A comparators
  localparam logic [ADDR_W-1:0] ADDR_RAWB = 8'h1c;  // Synchronised raw B comparators
  localparam logic [ADDR_W-1:0] ADDR_TRIP_BASE = 8'h40;  // Trip codes, one word per channel
  localparam int TRIP_IDX_LSB = 2;   // Channel index field of a trip address
  localparam int TRIP_IDX_W = 4;
  localparam logic [1:0] TRIP_PAGE = 2'h1;  // Address bits [7:6] of the trip block

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int CTRL_LOADED_BIT = 0;
  localparam int STAT_CALDONE_BIT = 0;
  localparam int TRIP_W = 6;        // Trip point code width
  localparam int TRIP_A_LSB = 0;    // A threshold code in trip word
  localparam int TRIP_B_LSB = 8;    // B threshold code in trip word
  localparam logic [TRIP_W-1:0] TRIP_ZERO_DETECT = 6'h00;  // 75 mV code, reset value

  // ----------------------------------------------------------------
  // Channel layout
  // ----------------------------------------------------------------
  localparam int NUM_CHAN = 10;
  localparam logic [NUM_CHAN-1:0] DIFF_MASK = 10'h00f;  // Channels one to four differential
  localparam int OCB_CH_LO = 3;     // Channel four, zero based
  localparam int OCB_CH_HI = 8;     // Channel nine, zero based

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 25;             // System clock
  localparam int TICK_MHZ = 8;             // Nominal filter clock
  localparam int FILT_ON_US = 64;          // Filtered settle time
  localparam int FILT_OFF_US = 16;         // Unfiltered settle time
  localparam int FILT_ON_TICKS = FILT_ON_US * TICK_MHZ;    // 512
  localparam int FILT_OFF_TICKS = FILT_OFF_US * TICK_MHZ;  // 128
  localparam int FCNT_W = 10;
  localparam int ACC_W = 6;

  // Calibration sequencing after reset
  typedef enum logic [0:0] {
    SVML_CAL_RUN,
    SVML_CAL_DONE
  } svml_cal_e;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } svml_req_s;

endpackage

// >>> tb/svml_link_partner.sv
// Far-end management controller model on the expander link
`timescale 1ns/1ns
module svml_link_partner import svml_pkg::*; #(
  parameter int NGPIO = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Link from the monitor
  input wire logic [NUM_CHAN-1:0] link_a_i,
  input wire logic [NUM_CHAN-1:0] link_b_i,
  input wire logic done_i,
  // Controls to send
  input wire logic [NGPIO-1:0] cmd_i,
  output logic [NGPIO-1:0] gpio_o,
  output logic early_o
);
  // Controls leave on a register, as a link shifter would launch them
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      gpio_o <= '0;
      early_o <= 1'b0;
    end else begin
      gpio_o <= cmd_i;
      // Status seen before calibration end would be untrusted data
      if (!done_i && (|link_a_i || |link_b_i)) begin
        early_o <= 1'b1;
      end
    end
  end
endmodule

// >>> tb/svml_monitor_props.sv
// Port-level concurrent checks for the supply voltage monitor
`timescale 1ns/1ns
module svml_monitor_props import svml_pkg::*; #(
  parameter int NCH = NUM_CHAN,
  parameter int NGPIO = 4,
  parameter logic [TRIP_W-1:0] HYST_MIN_CODE = 6'h10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Watched ports
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [NCH-1:0] second_threshold_compare_i,
  input wire logic [NCH*TRIP_W-1:0] upper_trip_code_o,
  input wire logic [NCH-1:0] hyst_en_a_o,
  input wire logic [NCH-1:0] remote_ground_sense_en_o,
  input wire logic calibrate_o,
  input wire logic [NCH-1:0] expander_link_a_o,
  input wire logic [NCH-1:0] expander_link_b_o,
  input wire logic calibration_done_o,
  input wire logic [NGPIO-1:0] gpio_ctrl_o,
  input wire logic channel4_first_compare_o,
  input wire logic channel9_first_compare_o
);
  // ------------------------------------------
  // Common clocking
  // ------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Busy flag dropping marks the end of calibration
  sequence cal_end_s;
    calibrate_o ##1 !calibrate_o;
  endsequence
  // ------------------------------------------
  // Assertions
  // ------------------------------------------
  ocb_ch4_a: assert property (channel4_first_compare_o == expander_link_a_o[OCB_CH_LO])
    else $error("channel four tap differs from link");
  ocb_ch9_a: assert property (channel9_first_compare_o == expander_link_a_o[OCB_CH_HI])
    else $error("channel nine tap differs from link");
  link_gate_a: assert property (!calibration_done_o |->
    (expander_link_a_o | expander_link_b_o) == '0)
    else $error("status on link before calibration end");
  gpio_gate_a: assert property (!calibration_done_o |-> gpio_ctrl_o == '0)
    else $error("output control taken before calibration end");
  cal_end_a: assert property (cal_end_s |=> calibration_done_o)
    else $error("calibration ended without done");
  done_hold_a: assert property (calibration_done_o |=> calibration_done_o && !calibrate_o)
    else $error("done dropped or busy returned");
  diff_sense_a: assert property (!$past(reset_i) |->
    remote_ground_sense_en_o == DIFF_MASK[NCH-1:0])
    else $error("differential channel mask wrong");
  hyst_sel_a: assert property (hyst_en_a_o[0] ==
    ($past(upper_trip_code_o[TRIP_W-1:0]) >= HYST_MIN_CODE))
    else $error("hysteresis enable does not follow code");
  filt_steady_a: assert property ($changed(expander_link_b_o[0]) |->
    $past(second_threshold_compare_i[0], 300) == expander_link_b_o[0])
    else $error("link changed on a short pulse");
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside read cycle");
endmodule

bind svml_monitor svml_monitor_props #(.NCH(NCH), .NGPIO(NGPIO),
  .HYST_MIN_CODE(HYST_MIN_CODE)) i_props (
  .clk_i(clk_i), .reset_i(reset_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .second_threshold_compare_i(second_threshold_compare_i),
  .upper_trip_code_o(upper_trip_code_o), .hyst_en_a_o(hyst_en_a_o),
  .remote_ground_sense_en_o(remote_ground_sense_en_o), .calibrate_o(calibrate_o),
  .expander_link_a_o(expander_link_a_o), .expander_link_b_o(expander_link_b_o),
  .calibration_done_o(calibration_done_o), .gpio_ctrl_o(gpio_ctrl_o),
  .channel4_first_compare_o(channel4_first_compare_o),
  .channel9_first_compare_o(channel9_first_compare_o));

// >>> tb/tb.sv
// Self-checking bench for the supply voltage monitor
`timescale 1ns/1ns
module tb;
  import svml_pkg::*;
  // ------------------------------------------
  // Signals
  // ------------------------------------------
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [NUM_CHAN-1:0] a_in = '1;  // Rails already up at power-on
  logic [NUM_CHAN-1:0] b_in = '1;
  logic [NUM_CHAN*TRIP_W-1:0] up_code;
  logic [NUM_CHAN*TRIP_W-1:0] lo_code;
  logic [NUM_CHAN-1:0] hy_a;
  logic [NUM_CHAN-1:0] hy_b;
  logic [NUM_CHAN-1:0] diff_en;
  logic [NUM_CHAN-1:0] link_a;
  logic [NUM_CHAN-1:0] link_b;
  logic cal_busy;
  logic done;
  logic ocb4;
  logic ocb9;
  logic early;
  logic [3:0] cmd = 4'hf;  // Controller requests outputs from the start
  logic [3:0] gpio_in;
  logic [3:0] gpio_out;
  logic [31:0] d;
  int n;
  int cycles = 0;
  int fail_count = 0;
  int cmp_count = 0;
  // ------------------------------------------
  // Instances
  // ------------------------------------------
  // Short calibration keeps the run brief
  svml_monitor #(.CAL_US(1)) i_svml_monitor (.clk_i(clk_i), .reset_i(reset_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .first_threshold_compare_i(a_in), .second_threshold_compare_i(b_in),
    .upper_trip_code_o(up_code), .lower_trip_code_o(lo_code), .hyst_en_a_o(hy_a),
    .hyst_en_b_o(hy_b), .remote_ground_sense_en_o(diff_en), .calibrate_o(cal_busy),
    .expander_link_a_o(link_a), .expander_link_b_o(link_b), .calibration_done_o(done),
    .expander_link_gpio_i(gpio_in), .gpio_ctrl_o(gpio_out),
    .channel4_first_compare_o(ocb4), .channel9_first_compare_o(ocb9));
  svml_link_partner i_svml_link_partner (.clk_i(clk_i), .reset_i(reset_i), .link_a_i(link_a),
    .link_b_i(link_b), .done_i(done), .cmd_i(cmd), .gpio_o(gpio_in), .early_o(early));
  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic waitn(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  // Edges until a link bit reaches a level, bounded
  task automatic meas(input bit lb, input int ch, input logic v);
    n = 0;
    do begin
      waitn(1);
      n++;
    end while (((lb ? link_b[ch] : link_a[ch]) !== v) && n < 3000);
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  // Outputs silent until calibration, then raised rails appear
  task automatic t_cal();
    meas(1'b0, 0, 1'b1);
    chk("done", done, 1'b1);
    chk("early", early, 1'b0);
    chk("diff", diff_en, 10'h00f);
    chk("busy", cal_busy, 1'b0);
    chk("zero_det", up_code[5:0], 6'h00);
    waitn(450);
    chk("all_a", link_a, 10'h3ff);
    chk("gpio", gpio_out, 4'hf);
    rreg(ADDR_STAT, d);
    chk("stat", d, 32'h1);
    a_in <= '0;
    b_in <= '0;
    cmd <= 4'h5;
    waitn(450);
    chk("all_b", link_b, 10'h000);
    chk("gpio5", gpio_out, 4'h5);
  endtask
  // Trip codes and hysteresis at both sides of the first hysteretic code
  task automatic t_regs();
    wreg(ADDR_TRIP_BASE, 32'h0512);
    wreg(8'h64, 32'h100f);
    waitn(2);
    chk("up0", up_code[5:0], 6'h12);
    chk("lo0", lo_code[5:0], 6'h05);
    chk("hy0", {hy_a[0], hy_b[0]}, 2'b10);
    chk("up9", up_code[59:54], 6'h0f);
    chk("hy9", {hy_a[9], hy_b[9]}, 2'b01);
    rreg(8'h64, d);
    chk("trip9", d, 32'h100f);
    rreg(8'h30, d);
    chk("unmapped", d, 32'h0);
  endtask
  // Unfiltered delay, a short pulse dropped, status read back
  task automatic t_off();
    b_in[0] <= 1'b1;
    meas(1'b1, 0, 1'b1);
    chk("rise_off", n >= 400 && n <= 410, 1'b1);
    rreg(ADDR_RAWB, d);
    chk("rawb", d[0], 1'b1);
    rreg(ADDR_OUTB, d);
    chk("outb", d[0], 1'b1);
    b_in[0] <= 1'b0;
    waitn(300);
    b_in[0] <= 1'b1;
    waitn(200);  // Inside the span a passed pulse would show low
    chk("pulse_off", link_b[0], 1'b1);
    b_in[0] <= 1'b0;
    meas(1'b1, 0, 1'b0);
    chk("fall_off", n >= 400 && n <= 410, 1'b1);
  endtask
  // Window mux on channel four, only once configuration is loaded
  task automatic t_win();
    logic [2:0] rows [3];
    rows = '{3'b011, 3'b110, 3'b000};
    wreg(8'h4c, 32'h2030);
    wreg(ADDR_WIN, 32'h8);
    b_in[3] <= 1'b1;
    a_in[8] <= 1'b1;
    waitn(450);
    chk("unloaded", link_a[3], 1'b0);
    chk("ocb9", ocb9, 1'b1);
    wreg(ADDR_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      a_in[3] <= rows[i][2];
      b_in[3] <= rows[i][1];
      waitn(450);
      chk("win", link_a[3], rows[i][0]);
      chk("ocb4", ocb4, rows[i][0]);
      chk("b_kept", link_b[3], rows[i][1]);
    end
  endtask
  // Filtered delay and a long but sub-limit pulse
  task automatic t_on();
    wreg(ADDR_FILT, 32'h3ff);
    b_in[1] <= 1'b1;
    meas(1'b1, 1, 1'b1);
    chk("rise_on", n >= 1600 && n <= 1612, 1'b1);
    b_in[1] <= 1'b0;
    waitn(1200);
    b_in[1] <= 1'b1;
    waitn(800);  // Inside the span a passed pulse would show low
    chk("pulse_on", link_b[1], 1'b1);
  endtask
  // ------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    t_cal();
    t_regs();
    t_off();
    t_win();
    t_on();
    end_of_test();
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
endmodule
